// ==== hwi_irq_power.sv ====
// interrupt status, enable gating, interrupt pin routing and low-power mode control
`timescale 1ns/1ps
//
// Contract
// - events set sticky flags until register read
// - read clears only flags whose source ended
// - flag registers read-only, zero after reset
// - cleared individual enable blocks flag setting
// - open or shorted diode pins set fault
// - enabled fault loads sensor-error code, except
// - faults reach interrupt only through error reading
// - sensor-error reading forces zone fans full
// - disabled diode: no fault, reading zero when its pins show a fault
// - config bits route interrupt to pins
// - global enable gates the interrupt
// - group enables gate temp, voltage, fan
// - temperature error drives interrupt low
// - voltage or fan error drives interrupt
// - interrupt held while any non-fault flag set
// - alert response call deasserts interrupt
// - interrupt only active while monitoring
// - start and mode bits pick power mode
// - lock freezes start and mode bits
// - sleep keeps oscillator, stops conversion, full access
// - shutdown stops all, reads zero, writes reach only special-function bits 2:0 and the whole pin config
module hwi_irq_power
  import hwi_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire hwi_pkg::hwi_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire hwi_pkg::hwi_event_t conv_event,
  input wire logic alert_response,
  input wire hwi_pkg::hwi_fault_t remote_one_fault_pins,
  input wire hwi_pkg::hwi_fault_t remote_two_fault_pins,
  input wire logic [7:0] remote_one_measured,
  input wire logic [7:0] remote_two_measured,
  input wire logic [7:0] fan_duty_auto,
  output logic irq_n,
  output logic fan_drive_pin_two_irq_n,
  output logic fan_drive_pin_two_irq_sel,
  output logic speed_sense_pin_three_irq_n,
  output logic speed_sense_pin_three_irq_sel,
  output logic [7:0] remote_one_reading,
  output logic [7:0] remote_two_reading,
  output logic [NUM_FANS-1:0] fan_full_duty,
  output logic oscillator_run,
  output logic converter_run
);
  import hwi_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic start;
    logic lock;
    logic [7:0] special_fn;
    logic [7:0] volt_en;
    logic [7:0] pin_config;
    logic [7:0] fan_en;
    logic [7:0] temp_en;
    logic [7:0] flags_one;
    logic [7:0] flags_two;
    logic irq_n;
    logic alert_mask;
    logic [7:0] rdata;
    logic [NUM_FANS-1:0] full_duty;
    logic osc_run;
    logic conv_run;
  } hwi_state_t;

  localparam hwi_state_t STATE_RESET = '{
    start: 1'b0, lock: 1'b0, special_fn: SF_RESET, volt_en: EN_RESET,
    pin_config: ZERO_BYTE, fan_en: EN_RESET, temp_en: EN_RESET,
    flags_one: FLAGS_RESET, flags_two: FLAGS_RESET, irq_n: 1'b1,
    alert_mask: 1'b0, rdata: ZERO_BYTE, full_duty: '1,
    osc_run: 1'b1, conv_run: 1'b0};

  hwi_state_t s_q, s_d;
  hwi_mode_t mode;
  logic diode_update;
  logic [NUM_DIODES-1:0] fault_flag;
  logic [NUM_DIODES-1:0] diode_force;
  logic [NUM_DIODES-1:0] error_load;
  logic [NUM_DIODES-1:0] diode_enable;
  logic [7:0] diode_reading [NUM_DIODES];
  hwi_fault_t fault_pins [NUM_DIODES];
  logic [7:0] measured [NUM_DIODES];

  // ------------------------------------------------------------
  // remote diode paths
  // ------------------------------------------------------------
  assign diode_update = conv_event.strobe & s_q.conv_run;
  assign diode_enable[0] = s_q.temp_en[TE_REMOTE1_BIT];
  assign diode_enable[1] = s_q.temp_en[TE_REMOTE2_BIT];
  assign fault_pins[0] = remote_one_fault_pins;
  assign fault_pins[1] = remote_two_fault_pins;
  assign measured[0] = remote_one_measured;
  assign measured[1] = remote_two_measured;

  generate
    for (genvar g = 0; g < NUM_DIODES; g++) begin : g_diode
      hwi_diode_path u_diode (
        .clock(clock),
        .rst(rst),
        .update(diode_update),
        .diode_enable(diode_enable[g]),
        .fault_pins(fault_pins[g]),
        .measured(measured[g]),
        .fault_flag(fault_flag[g]),
        .reading(diode_reading[g]),
        .force_full(diode_force[g])
      );
      // the error code loaded on this strobe must count in the same conversion, not one later
      assign error_load[g] = fault_flag[g] & ~fault_pins[g].neg_to_ground;
    end
  endgenerate

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] src1;
    logic [7:0] src2;
    logic [7:0] en1;
    logic [7:0] en2;
    logic temp_hit;
    logic volt_hit;
    logic fan_hit;
    logic shutdown;
    logic irq_active;
    src1 = ZERO_BYTE;
    src2 = ZERO_BYTE;
    en1 = ZERO_BYTE;
    en2 = ZERO_BYTE;
    temp_hit = 1'b0;
    volt_hit = 1'b0;
    fan_hit = 1'b0;
    shutdown = 1'b0;
    irq_active = 1'b0;
    s_d = s_q;

    unique case ({s_q.start, s_q.special_fn[SF_LOW_POWER_SELECT_BIT]})
      2'b00: mode = HWI_SLEEP;
      2'b01: mode = HWI_SHUTDOWN;
      default: mode = HWI_MONITOR;
    endcase
    shutdown = (mode == HWI_SHUTDOWN);

    // live sources: sequencer sources plus diode error readings and faults
    src1 = conv_event.flags_one_src;
    src1[F1_REMOTE1_BIT] = src1[F1_REMOTE1_BIT] | diode_force[0] | error_load[0];
    src1[F1_REMOTE2_BIT] = src1[F1_REMOTE2_BIT] | diode_force[1] | error_load[1];
    src2 = conv_event.flags_two_src & ~F2_FAULT_MASK;
    src2[F2_FAULT1_BIT] = fault_flag[0];
    src2[F2_FAULT2_BIT] = fault_flag[1];

    // individual enables; temp enables are spread over the flag bits
    en1 = {s_q.temp_en[TE_REMOTE2_BIT], s_q.temp_en[TE_AMBIENT_BIT], s_q.temp_en[TE_REMOTE1_BIT],
           s_q.volt_en[5:1]};
    en2 = {s_q.volt_en[7:6], F2_FAULT_MASK[5:4], s_q.fan_en[4:1]};

    // read: clear only flags whose source has gone away
    if (reg_req.rd && !shutdown) begin
      if (reg_req.addr == ADDR_FLAGS_ONE) begin
        s_d.flags_one = s_q.flags_one & src1;
      end
      if (reg_req.addr == ADDR_FLAGS_TWO) begin
        s_d.flags_two = s_q.flags_two & src2;
      end
    end
    // set wins over a same-cycle clear
    if (conv_event.strobe && s_q.conv_run) begin
      s_d.flags_one = s_d.flags_one | (src1 & en1);
      s_d.flags_two = s_d.flags_two | (src2 & en2);
    end

    // register writes; flag registers ignore writes
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        ADDR_RUN_LOCK: begin
          if (!shutdown) begin
            if (!s_q.lock) begin
              s_d.start = reg_req.wdata[RL_START_BIT];
            end
            // lock is sticky until power-on reset
            s_d.lock = s_q.lock | reg_req.wdata[RL_LOCK_BIT];
          end
        end
        ADDR_SPECIAL_FN: begin
          if (shutdown) begin
            s_d.special_fn = (s_q.special_fn & ~SF_SHUTDOWN_MASK) | (reg_req.wdata & SF_SHUTDOWN_MASK);
          end else begin
            s_d.special_fn = reg_req.wdata;
          end
          if (s_q.lock) begin
            s_d.special_fn[SF_LOW_POWER_SELECT_BIT] = s_q.special_fn[SF_LOW_POWER_SELECT_BIT];
          end
          // re-enabling the global enable lets the pin reassert
          if (reg_req.wdata[SF_IRQ_EN_BIT]) begin
            s_d.alert_mask = 1'b0;
          end
        end
        ADDR_PIN_CONFIG: s_d.pin_config = reg_req.wdata;
        ADDR_VOLT_EN: if (!shutdown) s_d.volt_en = reg_req.wdata;
        ADDR_FAN_EN: if (!shutdown) s_d.fan_en = reg_req.wdata;
        ADDR_TEMP_EN: if (!shutdown) s_d.temp_en = reg_req.wdata;
        default: ;
      endcase
    end

    // read data; in shutdown everything reads zero
    s_d.rdata = ZERO_BYTE;
    if (reg_req.rd && !shutdown) begin
      unique case (reg_req.addr)
        ADDR_RUN_LOCK: begin
          s_d.rdata[RL_START_BIT] = s_q.start;
          s_d.rdata[RL_LOCK_BIT] = s_q.lock;
          s_d.rdata[RL_READY_BIT] = s_q.conv_run;
        end
        ADDR_FLAGS_ONE: s_d.rdata = s_q.flags_one;
        ADDR_FLAGS_TWO: s_d.rdata = s_q.flags_two;
        ADDR_SPECIAL_FN: s_d.rdata = s_q.special_fn;
        ADDR_VOLT_EN: s_d.rdata = s_q.volt_en;
        ADDR_PIN_CONFIG: s_d.rdata = s_q.pin_config;
        ADDR_FAN_EN: s_d.rdata = s_q.fan_en;
        ADDR_TEMP_EN: s_d.rdata = s_q.temp_en;
        default: s_d.rdata = ZERO_BYTE;
      endcase
    end

    // interrupt: groups, then global, then operating mode
    temp_hit = s_q.temp_en[GRP_EN_BIT] & |(s_q.flags_one & F1_TEMP_MASK);
    volt_hit = s_q.volt_en[GRP_EN_BIT] &
               (|(s_q.flags_one & F1_VOLT_MASK) | |(s_q.flags_two & F2_VOLT_MASK));
    fan_hit = s_q.fan_en[GRP_EN_BIT] & |(s_q.flags_two & F2_FAN_MASK);
    // fault bits are left out of the sum on purpose
    irq_active = (temp_hit | volt_hit | fan_hit)
                 & s_q.special_fn[SF_IRQ_EN_BIT]
                 & (mode == HWI_MONITOR)
                 & ~s_q.alert_mask;
    if (alert_response && !s_q.irq_n) begin
      s_d.alert_mask = 1'b1;
      irq_active = 1'b0;
    end
    s_d.irq_n = ~irq_active;

    // power and fans
    s_d.osc_run = !shutdown;
    s_d.conv_run = (mode == HWI_MONITOR);
    for (int f = 0; f < NUM_FANS; f++) begin
      s_d.full_duty[f] = (mode != HWI_MONITOR) | (fan_duty_auto == FULL_DUTY);
    end
    // zone map: fan 0 follows remote one, fan 2 follows remote two
    s_d.full_duty[0] = s_d.full_duty[0] | diode_force[0];
    s_d.full_duty[NUM_FANS-1] = s_d.full_duty[NUM_FANS-1] | diode_force[1];
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata = s_q.rdata;
  assign irq_n = s_q.irq_n;
  assign fan_drive_pin_two_irq_sel = s_q.pin_config[PC_FAN2_BIT];
  assign speed_sense_pin_three_irq_sel = s_q.pin_config[PC_SPEED3_BIT];
  assign fan_drive_pin_two_irq_n = s_q.irq_n;
  assign speed_sense_pin_three_irq_n = s_q.irq_n;
  assign remote_one_reading = diode_reading[0];
  assign remote_two_reading = diode_reading[1];
  assign fan_full_duty = s_q.full_duty;
  assign oscillator_run = s_q.osc_run;
  assign converter_run = s_q.conv_run;
endmodule : hwi_irq_power

// ==== hwi_pkg.sv ====
// package: register map, field positions and carriers for the hardware-monitor interrupt and power block
package hwi_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] ADDR_RUN_LOCK = 8'h40;
  localparam logic [7:0] ADDR_FLAGS_ONE = 8'h41;
  localparam logic [7:0] ADDR_FLAGS_TWO = 8'h42;
  localparam logic [7:0] ADDR_SPECIAL_FN = 8'h7C;
  localparam logic [7:0] ADDR_VOLT_EN = 8'h7E;
  localparam logic [7:0] ADDR_PIN_CONFIG = 8'h7F;
  localparam logic [7:0] ADDR_FAN_EN = 8'h80;
  localparam logic [7:0] ADDR_TEMP_EN = 8'h82;
  // run_lock_control fields
  localparam int unsigned RL_START_BIT = 0;
  localparam int unsigned RL_LOCK_BIT = 1;
  localparam int unsigned RL_READY_BIT = 2;
  // special_function_control fields
  localparam int unsigned SF_LOW_POWER_SELECT_BIT = 0;
  localparam int unsigned SF_IRQ_EN_BIT = 2;
  localparam logic [7:0] SF_SHUTDOWN_MASK = 8'h07;
  // pin_config fields
  localparam int unsigned PC_SPEED3_BIT = 0;
  localparam int unsigned PC_FAN2_BIT = 1;
  // group enables sit at bit zero; individual enables above it
  localparam int unsigned GRP_EN_BIT = 0;
  // flags_one layout: [7:5] temperature errors, [4:0] voltage errors
  localparam int unsigned F1_REMOTE1_BIT = 5;
  localparam int unsigned F1_AMBIENT_BIT = 6;
  localparam int unsigned F1_REMOTE2_BIT = 7;
  localparam logic [7:0] F1_TEMP_MASK = 8'hE0;
  localparam logic [7:0] F1_VOLT_MASK = 8'h1F;
  // flags_two layout: [3:0] fan errors, [5:4] diode faults, [7:6] voltage errors
  localparam logic [7:0] F2_FAN_MASK = 8'h0F;
  localparam logic [7:0] F2_FAULT_MASK = 8'h30;
  localparam logic [7:0] F2_VOLT_MASK = 8'hC0;
  localparam int unsigned F2_FAULT1_BIT = 4;
  localparam int unsigned F2_FAULT2_BIT = 5;
  // temp enable layout: bit0 group, bit1 remote one, bit2 ambient, bit3 remote two
  localparam int unsigned TE_REMOTE1_BIT = 1;
  localparam int unsigned TE_AMBIENT_BIT = 2;
  localparam int unsigned TE_REMOTE2_BIT = 3;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] SF_RESET = 8'h40;
  localparam logic [7:0] EN_RESET = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] SENSOR_ERROR = 8'h80;
  localparam logic [7:0] DISABLED_READING = 8'h00;
  localparam logic [7:0] FULL_DUTY = 8'hFF;
  localparam int unsigned NUM_DIODES = 2;
  localparam int unsigned NUM_FANS = 3;

  typedef enum logic [1:0] {
    HWI_SLEEP = 2'b00,
    HWI_SHUTDOWN = 2'b01,
    HWI_MONITOR = 2'b10
  } hwi_mode_t;

  // serial register port, one access per strobe
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } hwi_reg_req_t;

  // per-diode pin fault condition from the analog front end
  typedef struct packed {
    logic open_circuit;
    logic pos_to_supply;
    logic pos_to_ground;
    logic neg_to_supply;
    logic neg_to_ground;
  } hwi_fault_t;

  // one sequencer event: live error sources sampled at conversion end
  typedef struct packed {
    logic strobe;
    logic [7:0] flags_one_src;
    logic [7:0] flags_two_src;
  } hwi_event_t;
endpackage : hwi_pkg

// ==== hwi_diode_path.sv ====
// one remote diode: fault decode, reading substitution and zone full-duty request
`timescale 1ns/1ps
module hwi_diode_path
  import hwi_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic update,
  input wire logic diode_enable,
  input wire hwi_pkg::hwi_fault_t fault_pins,
  input wire logic [7:0] measured,
  output logic fault_flag,
  output logic [7:0] reading,
  output logic force_full
);
  typedef struct packed {
    logic [7:0] reading;
  } hwi_dstate_t;

  hwi_dstate_t s_q, s_d;
  logic any_fault;

  always_comb begin
    any_fault = |fault_pins;
    s_d = s_q;
    if (update) begin
      if (!diode_enable && any_fault) begin
        s_d.reading = DISABLED_READING;
      end else if (diode_enable && any_fault && !fault_pins.neg_to_ground) begin
        s_d.reading = SENSOR_ERROR;
      end else begin
        s_d.reading = measured;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '{reading: ZERO_BYTE};
    end else begin
      s_q <= s_d;
    end
  end

  assign fault_flag = diode_enable & any_fault;
  assign reading = s_q.reading;
  assign force_full = (s_q.reading == SENSOR_ERROR);
endmodule : hwi_diode_path

// ==== hwi_irq_power_props.sv ====
// checker: interrupt pin and power-mode relations seen at the block ports
`timescale 1ns/1ps
module hwi_irq_power_props
  import hwi_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire hwi_pkg::hwi_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire hwi_pkg::hwi_event_t conv_event,
  input wire logic alert_response,
  input wire logic irq_n,
  input wire logic fan_drive_pin_two_irq_n,
  input wire logic fan_drive_pin_two_irq_sel,
  input wire logic speed_sense_pin_three_irq_sel,
  input wire logic [NUM_FANS-1:0] fan_full_duty,
  input wire logic oscillator_run,
  input wire logic converter_run
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic cfg_wr;
  logic sf_off;
  assign cfg_wr = reg_req.wr && reg_req.addr == ADDR_PIN_CONFIG;
  assign sf_off = reg_req.wr && reg_req.addr == ADDR_SPECIAL_FN && !reg_req.wdata[SF_IRQ_EN_BIT];
  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  AST_PIN_COPY: assert property (fan_drive_pin_two_irq_n == irq_n)
    else $error("pin two interrupt copy differs");
  AST_SEL_TWO: assert property (cfg_wr |=> fan_drive_pin_two_irq_sel == $past(reg_req.wdata[PC_FAN2_BIT]))
    else $error("pin two select not taken from config");
  AST_SEL_THREE: assert property (cfg_wr |=> speed_sense_pin_three_irq_sel == $past(reg_req.wdata[PC_SPEED3_BIT]))
    else $error("pin three select not taken from config");
  AST_GLOBAL_OFF: assert property (sf_off |=> ##1 irq_n)
    else $error("interrupt active with global enable cleared");
  AST_ALERT: assert property (alert_response && !irq_n |=> irq_n)
    else $error("alert response did not release interrupt");
  AST_FALL_CAUSE: assert property ($fell(irq_n) |-> $past(conv_event.strobe, 2) || $past(reg_req.wr, 2) || $past(reg_req.wr))
    else $error("interrupt fell without event or write");
  AST_LP_QUIET: assert property (!converter_run && !$past(converter_run) |-> irq_n)
    else $error("interrupt active in low power");
  AST_LP_FULL: assert property (!converter_run && !$past(converter_run) |-> &fan_full_duty)
    else $error("fans not full in low power");
  AST_OSC: assert property (converter_run |-> oscillator_run)
    else $error("converter running without oscillator");
  AST_SHUT_READ: assert property (!oscillator_run && reg_req.rd |=> reg_rdata == ZERO_BYTE)
    else $error("read data returned in shutdown");
  COV_ALERT: cover property (alert_response && !irq_n);
  COV_FALL: cover property ($fell(irq_n));
  COV_SHUT: cover property (!oscillator_run && reg_req.rd);
endmodule : hwi_irq_power_props
bind hwi_irq_power hwi_irq_power_props i_hwi_irq_power_props (.clock, .rst, .reg_req, .reg_rdata, .conv_event,
  .alert_response, .irq_n, .fan_drive_pin_two_irq_n, .fan_drive_pin_two_irq_sel, .speed_sense_pin_three_irq_sel,
  .fan_full_duty, .oscillator_run, .converter_run);

// ==== hwi_host_model.sv ====
// management host model: serial register accesses and the alert response call
`timescale 1ns/1ps
module hwi_host_model
  import hwi_pkg::*;
(
  input wire logic clock,
  input wire logic irq_n,
  input wire logic [7:0] reg_rdata,
  output hwi_pkg::hwi_reg_req_t reg_req,
  output logic alert_response
);
  initial begin
    reg_req = '0;
    alert_response = 1'b0;
  end
  // released fields show the inverse so stale values are never mistaken for live ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 reg_req = '{1'b1, 1'b0, a, d};
    @(posedge clock);
    #1 reg_req = '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1 reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock);
    #1 reg_req = '{1'b0, 1'b0, ~a, 8'hFF};
    d = reg_rdata;
  endtask : rd
  // global enable dropped around the status read so the pin re-asserts on a live event
  task automatic service(input logic [7:0] sf, output logic [7:0] d);
    wr(ADDR_SPECIAL_FN, sf & 8'hFB);
    rd(ADDR_FLAGS_ONE, d);
    wr(ADDR_SPECIAL_FN, sf | 8'h04);
  endtask : service
  // lag in cycles lets the host answer promptly or slowly
  task automatic alert(input int lag);
    repeat (lag) @(posedge clock);
    #1 alert_response = 1'b1;
    @(posedge clock);
    #1 alert_response = 1'b0;
  endtask : alert
endmodule : hwi_host_model

// ==== hwi_irq_power_bench.sv ====
// self-checking bench for the interrupt and power-mode block
`timescale 1ns/1ps
module hwi_irq_power_bench;
  import hwi_pkg::*;
  logic clock, rst, alert_response, irq_n, oscillator_run, converter_run;
  logic fan_drive_pin_two_irq_n, fan_drive_pin_two_irq_sel, speed_sense_pin_three_irq_n, speed_sense_pin_three_irq_sel;
  hwi_reg_req_t reg_req;
  hwi_event_t conv_event;
  hwi_fault_t remote_one_fault_pins, remote_two_fault_pins;
  logic [7:0] reg_rdata, remote_one_measured, remote_two_measured, fan_duty_auto;
  logic [7:0] remote_one_reading, remote_two_reading, d;
  logic [NUM_FANS-1:0] fan_full_duty;
  int mismatches;
  int compares;
  hwi_irq_power i_hwi_irq_power (.clock, .rst, .reg_req, .reg_rdata, .conv_event, .alert_response,
    .remote_one_fault_pins, .remote_two_fault_pins, .remote_one_measured, .remote_two_measured, .fan_duty_auto,
    .irq_n, .fan_drive_pin_two_irq_n, .fan_drive_pin_two_irq_sel, .speed_sense_pin_three_irq_n,
    .speed_sense_pin_three_irq_sel, .remote_one_reading, .remote_two_reading, .fan_full_duty, .oscillator_run,
    .converter_run);
  hwi_host_model i_hwi_host_model (.clock, .irq_n, .reg_rdata, .reg_req, .alert_response);
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  // sources stay as a level after the strobe, as the sequencer leaves them
  task automatic ev(input logic [7:0] a, input logic [7:0] b);
    @(posedge clock);
    #1 conv_event = '{1'b1, a, b};
    @(posedge clock);
    #1 conv_event.strobe = 1'b0;
  endtask : ev
  task automatic wrap_up;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    i_hwi_host_model.rd(ADDR_FLAGS_ONE, d);
    chk(d, FLAGS_RESET);
    i_hwi_host_model.rd(ADDR_FLAGS_TWO, d);
    chk(d, FLAGS_RESET);
    i_hwi_host_model.rd(ADDR_TEMP_EN, d);
    chk(d, EN_RESET);
    chk(irq_n, 1'b1);
    chk(fan_full_duty, 3'h7);
    $display("reset test done");
  endtask : t_reset
  task automatic t_flags;
    i_hwi_host_model.wr(ADDR_RUN_LOCK, 8'h01);
    ev(8'h20, 8'h00);
    cyc(1);
    chk(irq_n, 1'b1);
    i_hwi_host_model.wr(ADDR_SPECIAL_FN, 8'h44);
    cyc(1);
    chk(irq_n, 1'b0);
    i_hwi_host_model.wr(ADDR_FLAGS_ONE, 8'h00);
    i_hwi_host_model.rd(ADDR_FLAGS_ONE, d);
    chk(d, 8'h20);
    i_hwi_host_model.rd(ADDR_FLAGS_ONE, d);
    chk(d, 8'h20);
    ev(8'h00, 8'h00);
    i_hwi_host_model.rd(ADDR_FLAGS_ONE, d);
    chk(d, 8'h20);
    cyc(1);
    chk(irq_n, 1'b1);
    i_hwi_host_model.wr(ADDR_TEMP_EN, 8'hFD);
    ev(8'h20, 8'h00);
    i_hwi_host_model.rd(ADDR_FLAGS_ONE, d);
    chk(d, 8'h00);
    i_hwi_host_model.wr(ADDR_TEMP_EN, 8'hFF);
    i_hwi_host_model.wr(ADDR_VOLT_EN, 8'hFE);
    ev(8'h01, 8'h00);
    cyc(1);
    chk(irq_n, 1'b1);
    i_hwi_host_model.wr(ADDR_VOLT_EN, 8'hFF);
    cyc(1);
    chk(irq_n, 1'b0);
    i_hwi_host_model.service(8'h44, d);
    chk(d, 8'h01);
    cyc(1);
    chk(irq_n, 1'b0);
    i_hwi_host_model.alert(3);
    cyc(3);
    chk(irq_n, 1'b1);
    conv_event = '0;
    i_hwi_host_model.rd(ADDR_FLAGS_ONE, d);
    ev(8'h00, 8'h01);
    cyc(1);
    chk(irq_n, 1'b1);
    i_hwi_host_model.wr(ADDR_SPECIAL_FN, 8'h44);
    cyc(1);
    chk(irq_n, 1'b0);
    conv_event = '0;
    i_hwi_host_model.rd(ADDR_FLAGS_TWO, d);
    cyc(1);
    chk(irq_n, 1'b1);
    $display("flag test done");
  endtask : t_flags
  task automatic t_pins;
    i_hwi_host_model.wr(ADDR_PIN_CONFIG, 8'h02);
    cyc(1);
    chk({fan_drive_pin_two_irq_sel, speed_sense_pin_three_irq_sel}, 8'h02);
    i_hwi_host_model.wr(ADDR_PIN_CONFIG, 8'h01);
    cyc(1);
    chk({fan_drive_pin_two_irq_sel, speed_sense_pin_three_irq_sel}, 8'h01);
    chk(speed_sense_pin_three_irq_n, irq_n);
    $display("pin test done");
  endtask : t_pins
  task automatic t_diode;
    remote_one_fault_pins.open_circuit = 1'b1;
    ev(8'h00, 8'h00);
    cyc(2);
    chk(remote_one_reading, SENSOR_ERROR);
    chk(remote_two_reading, 8'h2A);
    chk(fan_full_duty[0], 1'b1);
    chk(fan_full_duty[NUM_FANS-1], 1'b0);
    chk(irq_n, 1'b0);
    i_hwi_host_model.rd(ADDR_FLAGS_TWO, d);
    chk(d, 8'h10);
    remote_one_fault_pins = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    ev(8'h00, 8'h00);
    cyc(2);
    chk(remote_one_reading, 8'h19);
    i_hwi_host_model.rd(ADDR_FLAGS_ONE, d);
    chk(d, 8'h20);
    cyc(1);
    chk(irq_n, 1'b1);
    remote_one_fault_pins = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    i_hwi_host_model.wr(ADDR_TEMP_EN, 8'hFD);
    ev(8'h00, 8'h00);
    cyc(2);
    chk(remote_one_reading, DISABLED_READING);
    chk(fan_full_duty[0], 1'b0);
    i_hwi_host_model.rd(ADDR_FLAGS_TWO, d);
    i_hwi_host_model.rd(ADDR_FLAGS_TWO, d);
    chk(d, 8'h00);
    remote_one_fault_pins = '0;
    i_hwi_host_model.wr(ADDR_TEMP_EN, 8'hFF);
    $display("diode test done");
  endtask : t_diode
  task automatic t_power;
    i_hwi_host_model.wr(ADDR_RUN_LOCK, 8'h00);
    cyc(2);
    chk({converter_run, oscillator_run, fan_full_duty}, 8'h0F);
    i_hwi_host_model.wr(ADDR_SPECIAL_FN, 8'h45);
    i_hwi_host_model.wr(ADDR_TEMP_EN, 8'h00);
    i_hwi_host_model.rd(ADDR_SPECIAL_FN, d);
    chk(oscillator_run, 1'b0);
    chk(d, ZERO_BYTE);
    i_hwi_host_model.wr(ADDR_SPECIAL_FN, 8'h44);
    i_hwi_host_model.rd(ADDR_TEMP_EN, d);
    chk(d, EN_RESET);
    i_hwi_host_model.wr(ADDR_RUN_LOCK, 8'h03);
    i_hwi_host_model.wr(ADDR_RUN_LOCK, 8'h00);
    i_hwi_host_model.wr(ADDR_SPECIAL_FN, 8'h45);
    cyc(2);
    chk({converter_run, oscillator_run}, 8'h03);
    chk(fan_full_duty, 3'h0);
    i_hwi_host_model.rd(ADDR_SPECIAL_FN, d);
    chk(d, 8'h44);
    $display("power test done");
  endtask : t_power
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    conv_event = '0;
    remote_one_fault_pins = '0;
    remote_two_fault_pins = '0;
    remote_one_measured = 8'h19;
    remote_two_measured = 8'h2A;
    fan_duty_auto = 8'h10;
    mismatches = 0;
    compares = 0;
    repeat (16) @(posedge clock);
    #1 rst = 1'b0;
    t_reset();
    t_flags();
    t_pins();
    t_diode();
    t_power();
    wrap_up();
  end
endmodule : hwi_irq_power_bench
